// >>> hw/pfs_defines.svh
// Constants for the converter fault shutdown block
//
// Behaviour
// - Boost fault comparator low forces every PWM gate signal low, both stages.
// - Boost fault comparator high lets PWM signals pass unchanged.
// - Inverter fault comparator low forces every PWM gate signal low, both stages.
// - Inverter fault comparator high lets PWM signals drive switches normally.
// - A comparator fault in either stage stops both boost and inverter stages.
// - Disable inputs act on outputs independently of the gate forcing path.
// - Low on boost disable input floats boost timer channel 0, raises interrupt.
// - Low on inverter disable input floats channels 3 and 4, raises interrupt.
// - Monitor stops boost when input DC voltage leaves its window.
// - Monitor stops boost on boosted voltage or boost current above limit.
// - Monitor stops inverter on full-bridge current above limit.
// - Monitor tracks AC voltage and current peaks, stops inverter above limit.
// - Monitor stops both stages on either switch temperature above limit.
// - Conversions are triggered once every fixed compare-match period.
`ifndef PFS_DEFINES_SVH
`define PFS_DEFINES_SVH

// Sample width
`define PFS_ADC_W 12
// Channel widths
`define PFS_BOOST_PINS 4
`define PFS_INV_PINS 6
// Synchroniser bit positions
`define PFS_SYN_BCMP 0
`define PFS_SYN_ICMP 1
`define PFS_SYN_BDIS 2
`define PFS_SYN_IDIS 3
`define PFS_SYN_W 4
// Timing
`define PFS_CLK_PERIOD_NS 25
`define PFS_TRIG_PERIOD_NS 50000
`define PFS_TRIG_CYCLES (`PFS_TRIG_PERIOD_NS / `PFS_CLK_PERIOD_NS)
`define PFS_TRIG_CNT_W 12
`define PFS_PEAK_CNT_W 16
`define PFS_PEAK_SAMPLES 400

`endif

// >>> hw/pfs_pkg.sv
// Types for the converter fault shutdown block
package pfs_pkg;

   typedef struct packed {
      logic [3:0] sync1;
      logic [3:0] sync2;
      logic [11:0] trig_cnt;
      logic trig;
      logic [11:0] vac_peak;
      logic [11:0] iac_peak;
      logic [15:0] peak_cnt;
      logic boost_dis;
      logic inv_dis;
      logic mon_boost_stop;
      logic mon_inv_stop;
      logic [3:0] boost_pwm;
      logic [5:0] inv_pwm;
   } pfs_state_t;

endpackage

// >>> hw/pfs_fault_shutdown.sv
// Converter fault shutdown: gate forcing, output disable and sample monitor
`timescale 1ns/10ps
`include "pfs_defines.svh"

module pfs_fault_shutdown #(
   parameter int PEAK_SAMPLES = `PFS_PEAK_SAMPLES
) (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_n,

   // Fault comparators, low on fault
   input wire logic i_boost_fault_cmp,
   input wire logic i_inverter_fault_cmp,

   // Output disable pins, low requests high impedance
   input wire logic i_boost_disable_in,
   input wire logic i_inverter_disable_in,

   // Software clears
   input wire logic i_boost_disable_clr,
   input wire logic i_inverter_disable_clr,
   input wire logic i_monitor_clr,

   // PWM from the timers
   input wire logic [`PFS_BOOST_PINS-1:0] i_boost_pwm,
   input wire logic [`PFS_INV_PINS-1:0] i_inverter_pwm,

   // Converted samples
   input wire logic i_sample_valid,
   input wire logic [`PFS_ADC_W-1:0] i_vin,
   input wire logic [`PFS_ADC_W-1:0] i_vdc,
   input wire logic [`PFS_ADC_W-1:0] i_idc,
   input wire logic [`PFS_ADC_W-1:0] i_ibrg,
   input wire logic [`PFS_ADC_W-1:0] i_vac,
   input wire logic [`PFS_ADC_W-1:0] i_iac,
   input wire logic [`PFS_ADC_W-1:0] i_tboost,
   input wire logic [`PFS_ADC_W-1:0] i_tbrg,

   // Limits
   input wire logic [`PFS_ADC_W-1:0] i_vin_lo,
   input wire logic [`PFS_ADC_W-1:0] i_vin_hi,
   input wire logic [`PFS_ADC_W-1:0] i_vdc_hi,
   input wire logic [`PFS_ADC_W-1:0] i_idc_hi,
   input wire logic [`PFS_ADC_W-1:0] i_ibrg_hi,
   input wire logic [`PFS_ADC_W-1:0] i_vac_hi,
   input wire logic [`PFS_ADC_W-1:0] i_iac_hi,
   input wire logic [`PFS_ADC_W-1:0] i_tboost_hi,
   input wire logic [`PFS_ADC_W-1:0] i_tbrg_hi,

   // Gate drives of boost timer channel 0
   output logic [`PFS_BOOST_PINS-1:0] o_boost_pwm_out,
   output logic [`PFS_BOOST_PINS-1:0] o_boost_pwm_oe,

   // Complementary gate drives of inverter channels 3 and 4
   output logic [`PFS_INV_PINS-1:0] o_inverter_pwm_out,
   output logic [`PFS_INV_PINS-1:0] o_inverter_pwm_oe,

   // Interrupts and status
   output logic o_boost_disable_irq,
   output logic o_inverter_disable_irq,
   output logic o_monitor_boost_stop,
   output logic o_monitor_inverter_stop,

   // Conversion trigger
   output logic o_adc_trigger
);

   //------------------------------------------------------------
   // Helpers
   //------------------------------------------------------------
   function automatic logic over_limit(
      input logic [`PFS_ADC_W-1:0] value,
      input logic [`PFS_ADC_W-1:0] limit
   );
      over_limit = value > limit;
   endfunction

   function automatic logic [`PFS_ADC_W-1:0] peak_of(
      input logic [`PFS_ADC_W-1:0] held,
      input logic [`PFS_ADC_W-1:0] sample,
      input logic restart
   );
      if (restart || sample > held) begin
         peak_of = sample;
      end else begin
         peak_of = held;
      end
   endfunction

   localparam logic [`PFS_TRIG_CNT_W-1:0] TRIG_LAST =
      `PFS_TRIG_CNT_W'(`PFS_TRIG_CYCLES - 1);
   localparam logic [`PFS_PEAK_CNT_W-1:0] PEAK_LAST =
      `PFS_PEAK_CNT_W'(PEAK_SAMPLES - 1);

   //------------------------------------------------------------
   // State
   //------------------------------------------------------------
   pfs_pkg::pfs_state_t state;
   pfs_pkg::pfs_state_t next_state;

   logic cmp_fault;
   logic boost_gate_off;
   logic inv_gate_off;
   logic peak_restart;
   logic [`PFS_ADC_W-1:0] vac_peak_new;
   logic [`PFS_ADC_W-1:0] iac_peak_new;
   logic boost_bad;
   logic inv_bad;
   logic temp_bad;

   //------------------------------------------------------------
   // Next state
   //------------------------------------------------------------
   always_comb begin
      next_state = state;

      // Pin synchronisers
      next_state.sync1[`PFS_SYN_BCMP] = i_boost_fault_cmp;
      next_state.sync1[`PFS_SYN_ICMP] = i_inverter_fault_cmp;
      next_state.sync1[`PFS_SYN_BDIS] = i_boost_disable_in;
      next_state.sync1[`PFS_SYN_IDIS] = i_inverter_disable_in;
      next_state.sync2 = state.sync1;

      // Comparator faults stop both stages
      cmp_fault = !state.sync2[`PFS_SYN_BCMP]
         || !state.sync2[`PFS_SYN_ICMP];

      // Conversion trigger period
      if (state.trig_cnt == TRIG_LAST) begin
         next_state.trig_cnt = '0;
         next_state.trig = 1'b1;
      end else begin
         next_state.trig_cnt = state.trig_cnt + 1'b1;
         next_state.trig = 1'b0;
      end

      // Peak tracking over a window of samples
      peak_restart = state.peak_cnt == PEAK_LAST;
      vac_peak_new = peak_of(state.vac_peak, i_vac, peak_restart);
      iac_peak_new = peak_of(state.iac_peak, i_iac, peak_restart);

      // Monitor checks on each fresh sample
      boost_bad = (i_vin < i_vin_lo) || over_limit(i_vin, i_vin_hi)
         || over_limit(i_vdc, i_vdc_hi) || over_limit(i_idc, i_idc_hi);
      inv_bad = over_limit(i_ibrg, i_ibrg_hi)
         || over_limit(vac_peak_new, i_vac_hi)
         || over_limit(iac_peak_new, i_iac_hi);
      temp_bad = over_limit(i_tboost, i_tboost_hi)
         || over_limit(i_tbrg, i_tbrg_hi);

      // Monitor stops latch; a new violation beats a clear
      if (i_monitor_clr) begin
         next_state.mon_boost_stop = 1'b0;
         next_state.mon_inv_stop = 1'b0;
      end
      if (i_sample_valid) begin
         next_state.vac_peak = vac_peak_new;
         next_state.iac_peak = iac_peak_new;
         if (peak_restart) begin
            next_state.peak_cnt = '0;
         end else begin
            next_state.peak_cnt = state.peak_cnt + 1'b1;
         end
         if (boost_bad || temp_bad) begin
            next_state.mon_boost_stop = 1'b1;
         end
         if (inv_bad || temp_bad) begin
            next_state.mon_inv_stop = 1'b1;
         end
      end

      // Output disable latches, separate from gate forcing
      if (i_boost_disable_clr && state.sync2[`PFS_SYN_BDIS]) begin
         next_state.boost_dis = 1'b0;
      end
      if (!state.sync2[`PFS_SYN_BDIS]) begin
         next_state.boost_dis = 1'b1;
      end
      if (i_inverter_disable_clr && state.sync2[`PFS_SYN_IDIS]) begin
         next_state.inv_dis = 1'b0;
      end
      if (!state.sync2[`PFS_SYN_IDIS]) begin
         next_state.inv_dis = 1'b1;
      end

      // Gate forcing
      boost_gate_off = cmp_fault || state.mon_boost_stop;
      inv_gate_off = cmp_fault || state.mon_inv_stop;
      if (boost_gate_off) begin
         next_state.boost_pwm = '0;
      end else begin
         next_state.boost_pwm = i_boost_pwm;
      end
      if (inv_gate_off) begin
         next_state.inv_pwm = '0;
      end else begin
         next_state.inv_pwm = i_inverter_pwm;
      end
   end

   //------------------------------------------------------------
   // Registers
   //------------------------------------------------------------
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state <= '0;
         state.sync1 <= '1;
         state.sync2 <= '1;
      end else begin
         state <= next_state;
      end
   end

   //------------------------------------------------------------
   // Outputs
   //------------------------------------------------------------
   always_comb begin
      o_boost_pwm_out = state.boost_pwm;
      o_boost_pwm_oe = {`PFS_BOOST_PINS{!state.boost_dis}};
      o_inverter_pwm_out = state.inv_pwm;
      o_inverter_pwm_oe = {`PFS_INV_PINS{!state.inv_dis}};
      o_boost_disable_irq = state.boost_dis;
      o_inverter_disable_irq = state.inv_dis;
      o_monitor_boost_stop = state.mon_boost_stop;
      o_monitor_inverter_stop = state.mon_inv_stop;
      o_adc_trigger = state.trig;
   end

endmodule // pfs_fault_shutdown

// >>> verification/pfs_fault_monitor.sv
// Port checker for the converter fault shutdown block
`timescale 1ns/10ps
`include "pfs_defines.svh"
module pfs_fault_monitor (
   // Pins and gate drives
   input wire logic i_sys_clk, i_rst_n, i_boost_fault_cmp, i_inverter_fault_cmp,
   input wire logic i_boost_disable_in, i_boost_disable_clr,
   input wire logic [`PFS_BOOST_PINS-1:0] i_boost_pwm, o_boost_pwm_out, o_boost_pwm_oe,
   input wire logic [`PFS_INV_PINS-1:0] i_inverter_pwm, o_inverter_pwm_out,
   // Monitor and status
   input wire logic i_sample_valid, o_boost_disable_irq,
   input wire logic [`PFS_ADC_W-1:0] i_idc, i_idc_hi, i_ibrg, i_ibrg_hi,
   input wire logic o_monitor_boost_stop, o_monitor_inverter_stop, o_adc_trigger
);
   logic [11:0] gap;
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);
   // ----
   // Gate forcing and output disable
   // ----
   sequence s_gates_low;
      o_boost_pwm_out == '0 && o_inverter_pwm_out == '0;
   endsequence
   a_boost_fault_low: assert property ($fell(i_boost_fault_cmp) |-> ##3 s_gates_low)
      else $error("gates not low after boost fault");
   a_inv_fault_low: assert property ($fell(i_inverter_fault_cmp) |-> ##3 s_gates_low)
      else $error("gates not low after inverter fault");
   a_pwm_pass_through: assert property (
      (i_boost_fault_cmp && i_inverter_fault_cmp)[*3] ##1
      !(o_monitor_boost_stop || o_monitor_inverter_stop) |=>
      o_boost_pwm_out == $past(i_boost_pwm) && o_inverter_pwm_out == $past(i_inverter_pwm))
      else $error("gates differ from pwm");
   a_boost_dis_float: assert property (
      $fell(i_boost_disable_in) |-> ##3 (o_boost_pwm_oe == '0 && o_boost_disable_irq))
      else $error("boost outputs not floated");
   a_dis_held_latched: assert property (
      o_boost_disable_irq && !i_boost_disable_clr |=> o_boost_disable_irq && o_boost_pwm_oe == '0)
      else $error("disable state dropped");
   // ----
   // Sample monitor and trigger
   // ----
   sequence s_boost_stopped;
      o_monitor_boost_stop ##1 o_boost_pwm_out == '0;
   endsequence
   a_idc_over_stop: assert property (i_sample_valid && i_idc > i_idc_hi |=> s_boost_stopped)
      else $error("no boost stop on current");
   a_ibrg_over_stop: assert property (
      i_sample_valid && i_ibrg > i_ibrg_hi |=> o_monitor_inverter_stop)
      else $error("no inverter stop on bridge current");
   always_ff @(posedge i_sys_clk or negedge i_rst_n)
      if (!i_rst_n) gap <= 12'h000;
      else gap <= o_adc_trigger ? 12'h001 : gap + 12'h001;
   a_trig_period: assert property (o_adc_trigger ? gap == 12'h7d0 : gap < 12'h7d0)
      else $error("trigger period wrong");
endmodule // pfs_fault_monitor
bind pfs_fault_shutdown pfs_fault_monitor pfs_fault_monitor_i (.*);

// >>> verification/pfs_power_stage.sv
// Far side model: fault comparators and gate drivers
`timescale 1ns/10ps
module pfs_power_stage (
   // Overloads requested by the bench
   input wire logic i_boost_over,
   input wire logic i_inverter_over,
   // Gate pins of the block
   input wire logic [3:0] i_boost_pwm_out,
   input wire logic [3:0] i_boost_pwm_oe,
   input wire logic [5:0] i_inverter_pwm_out,
   input wire logic [5:0] i_inverter_pwm_oe,
   // Comparator and disable lines, low on fault
   output logic o_boost_fault_cmp,
   output logic o_inverter_fault_cmp,
   output logic o_disable_n,
   // Levels at the switches
   output logic [3:0] o_boost_gate,
   output logic [5:0] o_inverter_gate
);
   assign o_boost_fault_cmp = !i_boost_over;
   assign o_inverter_fault_cmp = !i_inverter_over;
   // Either detection reaches both disable pins
   assign o_disable_n = !(i_boost_over || i_inverter_over);
   // Floated gates fall to the driver pull-down
   assign o_boost_gate = i_boost_pwm_out & i_boost_pwm_oe;
   assign o_inverter_gate = i_inverter_pwm_out & i_inverter_pwm_oe;
endmodule // pfs_power_stage

// >>> verification/testbench.sv
// Self-checking bench for the converter fault shutdown block
`timescale 1ns/10ps
module testbench;
   logic clk = 1'b0, rst_n = 1'b0, bover = 1'b0, iover = 1'b0, clr = 1'b0, mclr = 1'b0;
   logic valid = 1'b0, bcmp, icmp, dis_n, birq, iirq, bstop, istop, trig;
   logic [3:0] bpwm = 4'h0, bout, boe, bgate;
   logic [5:0] ipwm = 6'h00, iout, ioe, igate;
   logic [11:0] s [8];
   logic [11:0] lim [9];
   int n_errors = 0, check_count = 0;
   always #12.5 clk = ~clk;
   pfs_fault_shutdown #(.PEAK_SAMPLES(4)) pfs_fault_shutdown_i (
      .i_sys_clk(clk), .i_rst_n(rst_n), .i_boost_fault_cmp(bcmp), .i_inverter_fault_cmp(icmp),
      .i_boost_disable_in(dis_n), .i_inverter_disable_in(dis_n), .i_boost_disable_clr(clr),
      .i_inverter_disable_clr(clr), .i_monitor_clr(mclr), .i_boost_pwm(bpwm),
      .i_inverter_pwm(ipwm), .i_sample_valid(valid), .i_vin(s[0]), .i_vdc(s[1]),
      .i_idc(s[2]), .i_ibrg(s[3]), .i_vac(s[4]), .i_iac(s[5]), .i_tboost(s[6]), .i_tbrg(s[7]),
      .i_vin_lo(lim[0]), .i_vin_hi(lim[1]), .i_vdc_hi(lim[2]), .i_idc_hi(lim[3]),
      .i_ibrg_hi(lim[4]), .i_vac_hi(lim[5]), .i_iac_hi(lim[6]), .i_tboost_hi(lim[7]),
      .i_tbrg_hi(lim[8]), .o_boost_pwm_out(bout), .o_boost_pwm_oe(boe),
      .o_inverter_pwm_out(iout), .o_inverter_pwm_oe(ioe), .o_boost_disable_irq(birq),
      .o_inverter_disable_irq(iirq), .o_monitor_boost_stop(bstop),
      .o_monitor_inverter_stop(istop), .o_adc_trigger(trig));
   pfs_power_stage pfs_power_stage_i (.i_boost_over(bover), .i_inverter_over(iover),
      .i_boost_pwm_out(bout), .i_boost_pwm_oe(boe), .i_inverter_pwm_out(iout),
      .i_inverter_pwm_oe(ioe), .o_boost_fault_cmp(bcmp), .o_inverter_fault_cmp(icmp),
      .o_disable_n(dis_n), .o_boost_gate(bgate), .o_inverter_gate(igate));
   // ----
   // Shared tasks
   // ----
   task step(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask
   task chk(input logic [23:0] got, exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task stop_test;
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // ----
   // Scenarios
   // ----
   task t_pass;
      bpwm = 4'ha;
      ipwm = 6'h2d;
      step(2);
      chk({bgate, igate}, {bpwm, ipwm});
      bpwm = ~bpwm;
      ipwm = ~ipwm;
      step(2);
      chk({bgate, igate}, {bpwm, ipwm});
   endtask
   task t_fault(input logic inv);
      bpwm = 4'hf;
      ipwm = 6'h3f;
      bover = ~inv;
      iover = inv;
      step(4);
      chk({bgate, igate, boe, ioe, birq, iirq}, 24'h000003);
      clr = 1'b1;
      step(1);
      clr = 1'b0;
      step(1);
      chk({boe, ioe, birq, iirq}, 24'h000003);
      bover = 1'b0;
      iover = 1'b0;
      step(4);
      chk({bout, iout, boe, ioe, birq, iirq}, 24'h3ff003);
      clr = 1'b1;
      step(1);
      clr = 1'b0;
      chk({bgate, igate, birq, iirq}, 24'h000ffc);
   endtask
   task t_mon;
      logic [1:0] e [9] = '{2'h2, 2'h2, 2'h2, 2'h2, 2'h1, 2'h1, 2'h1, 2'h3, 2'h3};
      for (int k = 0; k < 9; k++) begin
         if (k == 0) s[0] = 12'h0ff;
         else s[k-1] = 12'h801;
         valid = 1'b1;
         step(1);
         valid = 1'b0;
         chk({bstop, istop}, e[k]);
         step(1);
         chk({bgate & {4{e[k][1]}}, igate & {6{e[k][0]}}}, 24'h0);
         foreach (s[j]) s[j] = 12'h400;
         repeat (5) begin
            valid = 1'b1;
            step(1);
            valid = 1'b0;
            step(1);
         end
         mclr = 1'b1;
         step(1);
         mclr = 1'b0;
         valid = 1'b1;
         step(1);
         valid = 1'b0;
         step(1);
         chk({bstop, istop}, 24'h0);
      end
   endtask
   task t_trig;
      int n;
      n = 0;
      while (trig !== 1'b1 && n < 2100) begin
         step(1);
         n++;
      end
      step(1);
      n = 1;
      while (trig !== 1'b1 && n < 2100) begin
         step(1);
         n++;
      end
      chk(n[23:0], 24'd2000);
   endtask
   initial begin
      foreach (s[k]) s[k] = 12'h400;
      foreach (lim[k]) lim[k] = (k == 0) ? 12'h100 : 12'h800;
      repeat (20) @(posedge clk);
      #2 rst_n = 1'b1;
      step(2);
      t_pass;
      t_fault(1'b0);
      t_fault(1'b1);
      t_mon;
      t_trig;
      stop_test;
   end
   initial begin
      #250000;
      n_errors++;
      stop_test;
   end
endmodule // testbench
